// [core/light_sensor_defs.svh]
// Constants shared by the light sensor command and readout logic.
// Summary of operation
// RULE_01 - One 8-bit command register sets behaviour and holds until overwritten.
// RULE_02 - Only slave address 7'h44 is acknowledged; master uses it with R/W bit.
// RULE_03 - Each written data byte replaces the command and switches mode at once.
// RULE_04 - No sub-addresses; every read starts at the first result byte, ascending.
// RULE_05 - Read returns data low, data high, counter low, counter high.
// RULE_06 - Internal modes stop after two data bytes; counter bytes only in external.
// RULE_07 - Results change only at conversion end; earlier reads see the old result.
// RULE_08 - Address-only write re-executes the held command.
// RULE_09 - 8CH powers the converter down; 0CH resets it.
// RULE_10 - 00H and 04H convert first or second diode, self-timed.
// RULE_11 - 08H converts first minus second diode, two's complement, double time.
// RULE_12 - Difference mode integrates second diode first, then first diode.
// RULE_13 - Each 30H, 34H or 38H ends integration, latches result, starts next; the code latches only on a repeat of the running external command.
// RULE_14 - Master spaces external timing commands for 1ms to 100ms integrations.
// RULE_15 - Command bytes 1xxx_xxxx are stored and can be read back; the code stores 8CH but reads back the data bytes for it.
// RULE_16 - Oscillator cycles count a 16-bit counter latched as bytes three and four.
// RULE_17 - Master should wait about 120ms after an internal command before reading.
// RULE_18 - High power-down pin stops the whole device; low returns it to operation.
// RULE_19 - Internally timed integration lasts exactly 32768 oscillator cycles.
// RULE_20 - Master keeps external integrations below 65536 oscillator cycles.
// RULE_21 - The serial slave stays operational while converter is commanded down.
`ifndef LIGHT_SENSOR_DEFS_SVH
`define LIGHT_SENSOR_DEFS_SVH

// ==========================================================================
// Bus identity and commands
`define SLAVE_ADDR      7'h44
`define CMD_PWRDN       8'h8C
`define CMD_RESET       8'h0C
`define CMD_INT1        8'h00
`define CMD_INT2        8'h04
`define CMD_INTD        8'h08
`define CMD_EXT1        8'h30
`define CMD_EXT2        8'h34
`define CMD_EXTD        8'h38
`define CMD_TEST_BIT    7
`define CMD_RESET_VAL   8'h8C

// ==========================================================================
// Read byte order
`define IDX_DATA_LO     3'h0
`define IDX_DATA_HI     3'h1
`define IDX_CNT_LO      3'h2
`define IDX_CNT_HI      3'h3
`define IDX_INT_LIMIT   3'h2
`define IDX_LIMIT       3'h4

// ==========================================================================
// Timing
`define CLK_FREQ_HZ     100000000
`define OSC_FREQ_HZ     327600
`define OSC_DIV         (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define INT_CYCLES      32768

`endif

// [core/light_sensor_pkg.sv]
// Types shared by the light sensor logic.
package light_sensor_pkg;
  `include "light_sensor_defs.svh"

  typedef enum logic [3:0] {
    MODE_OFF, MODE_RST, MODE_INT1, MODE_INT2, MODE_INTD,
    MODE_EXT1, MODE_EXT2, MODE_EXTD, MODE_TEST, MODE_NONE
  } conv_mode_t;

  typedef enum logic [2:0] {
    LS_IDLE, LS_ADDR, LS_ACK_A, LS_WDATA, LS_ACK_W, LS_RDATA, LS_MACK
  } link_state_t;

  typedef struct packed {
    logic [7:0]  cmd;
    logic        ext;
    logic [15:0] data;
    logic [15:0] count;
  } snapshot_t;

  function automatic conv_mode_t decode_mode(input logic [7:0] c);
    conv_mode_t m;
    m = MODE_NONE;
    unique case (c)
      `CMD_PWRDN: m = MODE_OFF;
      `CMD_RESET: m = MODE_RST;
      `CMD_INT1:  m = MODE_INT1;
      `CMD_INT2:  m = MODE_INT2;
      `CMD_INTD:  m = MODE_INTD;
      `CMD_EXT1:  m = MODE_EXT1;
      `CMD_EXT2:  m = MODE_EXT2;
      `CMD_EXTD:  m = MODE_EXTD;
      default:    m = c[`CMD_TEST_BIT] ? MODE_TEST : MODE_NONE;
    endcase
    return m;
  endfunction

  function automatic logic is_ext(input conv_mode_t m);
    return (m == MODE_EXT1) || (m == MODE_EXT2) || (m == MODE_EXTD);
  endfunction

  function automatic logic is_conv(input conv_mode_t m);
    return is_ext(m) || (m == MODE_INT1) || (m == MODE_INT2) || (m == MODE_INTD);
  endfunction
endpackage

// [core/bit_sync.sv]
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  initial begin
    if (WIDTH < 1) $error("bit_sync needs WIDTH of at least one");
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// [core/event_xfer.sv]
// Single-cycle event crossing between two clock domains by a toggle.
`timescale 1ns/1ps
module event_xfer (
  input  wire logic src_clk_i,
  input  wire logic src_rst_i,
  input  wire logic src_pulse_i,
  input  wire logic dst_clk_i,
  input  wire logic dst_rst_i,
  output logic      dst_pulse_o
);
  logic src_tgl_r;
  logic meta_r;
  logic sync_r;
  logic seen_r;

  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      src_tgl_r <= 1'b0;
    end else if (src_pulse_i) begin
      src_tgl_r <= ~src_tgl_r;
    end
  end

  // Events must be at least two destination cycles apart or they cancel out.
  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      meta_r      <= 1'b0;
      sync_r      <= 1'b0;
      seen_r      <= 1'b0;
      dst_pulse_o <= 1'b0;
    end else begin
      meta_r      <= src_tgl_r;
      sync_r      <= meta_r;
      seen_r      <= sync_r;
      dst_pulse_o <= sync_r ^ seen_r;
    end
  end
endmodule

// [core/light_sensor_top.sv]
// Command register, integration timing and two-wire slave of the light sensor.
`timescale 1ns/1ps
`include "light_sensor_defs.svh"
module light_sensor_top
  import light_sensor_pkg::*;
#(
  parameter int OSC_DIV    = `OSC_DIV,
  parameter int INT_CYCLES = `INT_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        link_clk_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        power_down_pin_i,
  input  wire logic [15:0] first_diode_current_i,
  input  wire logic [15:0] second_diode_current_i,
  output logic             busy_o
);
  localparam logic [15:0] INT_LAST = 16'(INT_CYCLES - 1);
  localparam logic [15:0] DIV_LAST = 16'(OSC_DIV - 1);

  initial begin
    if (OSC_DIV < 2 || OSC_DIV > 65536) $error("OSC_DIV out of range");
    if (INT_CYCLES < 2 || INT_CYCLES > 65536) $error("INT_CYCLES out of range");
  end

  // ==========================================================================
  // Declarations
  logic        link_rst;
  logic        scl_s;
  logic        sda_s;
  logic        pd_link;
  logic        scl_d_r;
  logic        sda_d_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  link_state_t state_r;
  logic [2:0]  bit_cnt_r;
  logic        byte_full_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic        rw_r;
  logic        mack_r;
  logic [2:0]  byte_idx_r;
  logic [2:0]  next_idx;
  logic [7:0]  first_byte;
  logic [7:0]  next_byte;
  logic        sda_oe_r;
  logic [7:0]  cmd_byte_r;
  logic        cmd_req_r;
  logic        wr_only_r;
  logic        reexec_req_r;
  snapshot_t   snap_r;
  snapshot_t   snap_core;
  logic        pub_ev;
  logic        pub_r;

  logic        pd_core;
  logic        pd_prev_r;
  logic        cmd_ev;
  logic        reexec_ev;
  logic        exec;
  logic [7:0]  exec_cmd;
  conv_mode_t  exec_mode;
  logic [7:0]  cmd_r;
  conv_mode_t  mode_r;
  logic        active_r;
  logic        phase_r;
  logic [15:0] integ_cnt_r;
  logic [15:0] div_r;
  logic        tick_r;
  logic [15:0] second_hold_r;
  logic [15:0] res_data_r;
  logic [15:0] res_count_r;
  logic [15:0] conv_value;
  logic        int_end;
  logic        ext_latch;
  logic        conv_done;

  function automatic logic [7:0] sel_byte(input snapshot_t s, input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      `IDX_DATA_LO: b = (s.cmd[`CMD_TEST_BIT] && s.cmd != `CMD_PWRDN) ? s.cmd : s.data[7:0];
      `IDX_DATA_HI: b = s.data[15:8];
      `IDX_CNT_LO:  b = s.count[7:0];
      `IDX_CNT_HI:  b = s.count[15:8];
      default:      b = 8'hFF;
    endcase
    return b;
  endfunction

  // ==========================================================================
  // Link domain: pin synchronisers and bus conditions
  bit_sync #(.WIDTH(1)) u_rst_link (
    .clk_i (link_clk_i),
    .rst_i (1'b0),
    .d_i   (rst_i),
    .q_o   (link_rst)
  );

  bit_sync #(.WIDTH(3)) u_link_pins (
    .clk_i (link_clk_i),
    .rst_i (link_rst),
    .d_i   ({scl_i, sda_i, power_down_pin_i}),
    .q_o   ({scl_s, sda_s, pd_link})
  );

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign next_idx  = byte_idx_r + 3'h1;
  assign first_byte = sel_byte(snap_r, `IDX_DATA_LO);
  assign next_byte  = sel_byte(snap_r, next_idx);

  // ==========================================================================
  // Link domain: slave protocol
  // The slave keeps running whatever the converter mode is, so commands and reads
  // are served while the converter is down. Only the pin silences it.
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      state_r     <= LS_IDLE;
      bit_cnt_r   <= 3'h0;
      byte_full_r <= 1'b0;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      rw_r        <= 1'b0;
      mack_r      <= 1'b0;
      byte_idx_r  <= 3'h0;
      sda_oe_r    <= 1'b0;
    end else if (pd_link || stop_det) begin
      state_r     <= LS_IDLE; // RULE_18
      sda_oe_r    <= 1'b0;
    end else if (start_det) begin
      state_r     <= LS_ADDR; // RULE_21
      bit_cnt_r   <= 3'h0;
      byte_full_r <= 1'b0;
      sda_oe_r    <= 1'b0;
    end else begin
      unique case (state_r)
        LS_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        LS_ADDR, LS_WDATA: begin
          if (scl_rise) begin
            shift_r     <= {shift_r[6:0], sda_s};
            bit_cnt_r   <= bit_cnt_r + 3'h1;
            byte_full_r <= (bit_cnt_r == 3'h7);
          end else if (scl_fall && byte_full_r) begin
            byte_full_r <= 1'b0;
            if (state_r == LS_WDATA) begin
              sda_oe_r <= 1'b1;
              state_r  <= LS_ACK_W;
            end else if (shift_r[7:1] == `SLAVE_ADDR) begin
              sda_oe_r <= 1'b1; // RULE_02
              rw_r     <= shift_r[0];
              state_r  <= LS_ACK_A;
            end else begin
              state_r  <= LS_IDLE;
            end
          end
        end
        LS_ACK_A: begin
          if (scl_fall) begin
            byte_idx_r <= `IDX_DATA_LO; // RULE_04
            if (rw_r) begin
              tx_r     <= first_byte;
              sda_oe_r <= ~first_byte[7];
              state_r  <= LS_RDATA;
            end else begin
              sda_oe_r <= 1'b0;
              state_r  <= LS_WDATA;
            end
          end
        end
        LS_ACK_W: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            state_r  <= LS_WDATA;
          end
        end
        LS_RDATA: begin
          if (scl_rise) begin
            bit_cnt_r   <= bit_cnt_r + 3'h1;
            byte_full_r <= (bit_cnt_r == 3'h7);
          end else if (scl_fall) begin
            if (byte_full_r) begin
              byte_full_r <= 1'b0;
              sda_oe_r    <= 1'b0;
              state_r     <= LS_MACK;
            end else begin
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
            end
          end
        end
        LS_MACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_s;
          end else if (scl_fall) begin
            // Past the last byte the line stays released and the master reads ones.
            if (mack_r && next_idx < `IDX_LIMIT &&
                (snap_r.ext || next_idx < `IDX_INT_LIMIT)) begin
              byte_idx_r <= next_idx; // RULE_05
              tx_r       <= next_byte;
              sda_oe_r   <= ~next_byte[7];
              state_r    <= LS_RDATA;
            end else begin
              state_r    <= LS_IDLE; // RULE_06
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Link domain: command hand-off to the core
  // The byte is held until the next one, at least nine bus clocks later, so the
  // core may read it directly once the event has crossed.
  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      cmd_byte_r   <= `CMD_RESET_VAL;
      cmd_req_r    <= 1'b0;
      wr_only_r    <= 1'b0;
      reexec_req_r <= 1'b0;
    end else begin
      cmd_req_r    <= 1'b0;
      reexec_req_r <= (start_det || stop_det) && wr_only_r; // RULE_08
      if (start_det || stop_det || pd_link) begin
        wr_only_r <= 1'b0;
      end else if (state_r == LS_ACK_A && scl_fall && !rw_r) begin
        wr_only_r <= 1'b1;
      end else if (state_r == LS_WDATA && scl_fall && byte_full_r) begin
        cmd_byte_r <= shift_r; // RULE_03
        cmd_req_r  <= 1'b1;
        wr_only_r  <= 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      snap_r <= '0;
    end else if (pub_ev) begin
      snap_r <= snap_core;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      sda_o    <= 1'b0;
      sda_oe_o <= sda_oe_r;
    end
  end

  // ==========================================================================
  // Domain crossings
  event_xfer u_cmd_xfer (
    .src_clk_i   (link_clk_i),
    .src_rst_i   (link_rst),
    .src_pulse_i (cmd_req_r),
    .dst_clk_i   (clk_i),
    .dst_rst_i   (rst_i),
    .dst_pulse_o (cmd_ev)
  );

  event_xfer u_reexec_xfer (
    .src_clk_i   (link_clk_i),
    .src_rst_i   (link_rst),
    .src_pulse_i (reexec_req_r),
    .dst_clk_i   (clk_i),
    .dst_rst_i   (rst_i),
    .dst_pulse_o (reexec_ev)
  );

  event_xfer u_pub_xfer (
    .src_clk_i   (clk_i),
    .src_rst_i   (rst_i),
    .src_pulse_i (pub_r),
    .dst_clk_i   (link_clk_i),
    .dst_rst_i   (link_rst),
    .dst_pulse_o (pub_ev)
  );

  bit_sync #(.WIDTH(1)) u_pd_core (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (power_down_pin_i),
    .q_o   (pd_core)
  );

  // ==========================================================================
  // Core: command register and decode
  always_comb begin
    exec      = cmd_ev | reexec_ev | (pd_prev_r & ~pd_core);
    exec_cmd  = cmd_ev ? cmd_byte_r : cmd_r;
    exec_mode = decode_mode(exec_cmd); // RULE_09
    int_end   = active_r && tick_r && !is_ext(mode_r) && integ_cnt_r == INT_LAST; // RULE_19
    ext_latch = exec && active_r && is_ext(exec_mode) && exec_mode == mode_r; // RULE_13
    conv_done = (int_end && (mode_r != MODE_INTD || phase_r)) || ext_latch;
    unique case (mode_r)
      MODE_INT2, MODE_EXT2: conv_value = second_diode_current_i; // RULE_10
      MODE_INTD:            conv_value = first_diode_current_i - second_hold_r; // RULE_11
      MODE_EXTD:            conv_value = first_diode_current_i - second_diode_current_i;
      default:              conv_value = first_diode_current_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r     <= `CMD_RESET_VAL;
      mode_r    <= MODE_OFF;
      pd_prev_r <= 1'b0;
    end else begin
      pd_prev_r <= pd_core;
      if (cmd_ev) begin
        cmd_r <= cmd_byte_r; // RULE_01
      end
      if (exec) begin
        mode_r <= exec_mode; // RULE_15
      end
    end
  end

  // ==========================================================================
  // Core: oscillator and integration
  // The oscillator is a divided system clock; its drift is not modelled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      div_r  <= (div_r == DIV_LAST) ? 16'h0000 : div_r + 16'h0001;
      tick_r <= (div_r == DIV_LAST);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r    <= 1'b0;
      phase_r     <= 1'b0;
      integ_cnt_r <= 16'h0000;
    end else if (pd_core) begin
      active_r    <= 1'b0; // RULE_18
      phase_r     <= 1'b0;
      integ_cnt_r <= 16'h0000;
    end else if (exec) begin
      active_r    <= is_conv(exec_mode);
      phase_r     <= 1'b0;
      integ_cnt_r <= 16'h0000;
    end else if (active_r && tick_r) begin
      if (int_end) begin
        integ_cnt_r <= 16'h0000;
        phase_r     <= (mode_r == MODE_INTD) ? ~phase_r : 1'b0; // RULE_12
      end else begin
        integ_cnt_r <= integ_cnt_r + 16'h0001; // RULE_16
      end
    end
  end

  // ==========================================================================
  // Core: results and publication to the link
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_hold_r <= 16'h0000;
      res_data_r    <= 16'h0000;
      res_count_r   <= 16'h0000;
      pub_r         <= 1'b0;
      busy_o        <= 1'b0;
    end else begin
      busy_o <= active_r;
      pub_r  <= conv_done | cmd_ev;
      if (int_end && mode_r == MODE_INTD && !phase_r) begin
        second_hold_r <= second_diode_current_i;
      end
      if (conv_done) begin
        res_data_r  <= conv_value; // RULE_07
        res_count_r <= int_end ? integ_cnt_r + 16'h0001 : integ_cnt_r;
      end
    end
  end

  assign snap_core = '{cmd: cmd_r, ext: is_ext(mode_r), data: res_data_r, count: res_count_r};

  // ==========================================================================
  // Checks
  a_addr_match: assert property ( // RULE_02
    @(posedge link_clk_i) disable iff (link_rst)
    (state_r == LS_ACK_A && $past(state_r) == LS_ADDR) |-> shift_r[7:1] == `SLAVE_ADDR)
    else $error("Acknowledge given to a foreign address.");

  a_read_starts: assert property ( // RULE_04
    @(posedge link_clk_i) disable iff (link_rst)
    (state_r == LS_ACK_A && scl_fall && rw_r && !start_det && !stop_det && !pd_link)
      |=> state_r == LS_RDATA && byte_idx_r == 3'h0)
    else $error("Read did not start at the first byte.");

  a_int_two_bytes: assert property ( // RULE_06
    @(posedge link_clk_i) disable iff (link_rst)
    (state_r == LS_RDATA && !snap_r.ext) |-> byte_idx_r < `IDX_INT_LIMIT)
    else $error("Counter byte sent in an internal mode.");

  a_reexec_req: assert property ( // RULE_08
    @(posedge link_clk_i) disable iff (link_rst)
    (stop_det && wr_only_r) |=> reexec_req_r ##1 !reexec_req_r)
    else $error("Address-only write did not re-execute.");

  a_cmd_update: assert property ( // RULE_03
    @(posedge clk_i) disable iff (rst_i)
    cmd_ev |=> cmd_r == $past(cmd_byte_r) && mode_r == decode_mode($past(cmd_byte_r)))
    else $error("Command byte not taken.");

  a_result_hold: assert property ( // RULE_07
    @(posedge clk_i) disable iff (rst_i)
    !conv_done |=> $stable(res_data_r) && $stable(res_count_r))
    else $error("Result changed without a finished conversion.");

  a_int_period: assert property ( // RULE_19
    @(posedge clk_i) disable iff (rst_i)
    (int_end && mode_r == MODE_INT1 && !exec && !pd_core) |=> res_count_r == INT_LAST + 16'h0001)
    else $error("Internal period length wrong.");

  a_ext_latch: assert property ( // RULE_13
    @(posedge clk_i) disable iff (rst_i)
    (ext_latch && !pd_core) |=> res_count_r == $past(integ_cnt_r) && integ_cnt_r == 16'h0000
      && active_r)
    else $error("External command did not latch and restart.");

  a_diff_result: assert property ( // RULE_11
    @(posedge clk_i) disable iff (rst_i)
    (int_end && mode_r == MODE_INTD && phase_r)
      |=> res_data_r == $past(first_diode_current_i) - $past(second_hold_r))
    else $error("Difference result wrong.");

  a_pd_stops: assert property ( // RULE_18
    @(posedge clk_i) disable iff (rst_i)
    pd_core |=> !active_r ##1 !busy_o)
    else $error("Converter ran while the pin held power-down.");

  a_cnt_step: assert property ( // RULE_16
    @(posedge clk_i) disable iff (rst_i)
    (active_r && tick_r && !int_end && !exec && !pd_core)
      |=> integ_cnt_r == $past(integ_cnt_r) + 16'h0001)
    else $error("Integration counter missed an oscillator cycle.");
endmodule

// [tb/bus_master_model.sv]
// Behavioural two-wire bus master that stands on the far side of the sensor.
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // A quarter bit of 60 ns leaves the slave's link-side synchroniser ample margin.
  localparam int Q = 60;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start_cond();
    sda_low_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_low_o = 1'b1;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask
  task automatic stop_cond();
    sda_low_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_low_o = 1'b0;
    #Q;
  endtask
  task automatic put_bit(input logic b, output logic r);
    sda_low_o = ~b;
    #Q;
    scl_o = 1'b1;
    #Q;
    r = sda_i;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask
  // Sends tx MSB first while sampling the line; a released line reads back the slave's bits.
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(tx[i], r);
      rx[i] = r;
    end
    put_bit(~mack, r);
    ack = ~r;
  endtask
endmodule

// [tb/tb.sv]
// Self-checking testbench of the light sensor command and readout logic.
`timescale 1ns/1ps
module tb;
  import light_sensor_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        link_clk = 1'b0;
  logic        pd = 1'b0;
  logic [15:0] d1 = 16'h0235;
  logic [15:0] d2 = 16'h1234;
  wire         scl;
  wire         sda_low;
  wire         sda_o;
  wire         sda_oe;
  wire         busy;
  // Open-drain wire with a pull-up: low when either party pulls it.
  wire         sda_line = ~((sda_oe & ~sda_o) | sda_low);
  int          failures = 0;
  int          checks_done = 0;
  localparam int TB_DIV = 4;
  always #5 clk_i = ~clk_i;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  bus_master_model m (.sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
  light_sensor_top #(.OSC_DIV(TB_DIV), .INT_CYCLES(16)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .power_down_pin_i(pd), .first_diode_current_i(d1),
    .second_diode_current_i(d2), .busy_o(busy));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic write_cmd(input logic [7:0] c);
    logic [7:0] rx;
    logic       ack;
    m.start_cond();
    m.xfer(8'h88, 1'b0, rx, ack);
    check("address ack", ack, 8'h01);
    m.xfer(c, 1'b0, rx, ack);
    check("command ack", ack, 8'h01);
    m.stop_cond();
  endtask
  // Reads n bytes with no pointer; the last byte is refused by the master.
  task automatic read_res(input int n, output logic [31:0] v);
    logic [7:0] rx;
    logic       ack;
    m.start_cond();
    m.xfer(8'h89, 1'b0, rx, ack);
    check("read address ack", ack, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hFF, i < n - 1, rx, ack);
      v[8*i+:8] = rx;
    end
    m.stop_cond();
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_internal();
    logic [7:0]  cmds [3] = '{8'h00, 8'h04, 8'h08};
    logic [15:0] exp;
    logic [31:0] v;
    for (int k = 0; k < 3; k++) begin
      exp = (k == 0) ? d1 : (k == 1) ? d2 : d1 - d2;
      write_cmd(cmds[k]);
      repeat (300) @(negedge clk_i);
      read_res(3, v);
      check("reading low", v[7:0], exp[7:0]);
      check("reading high", v[15:8], exp[15:8]);
      check("third byte", v[23:16], 8'hFF);
    end
  endtask
  task automatic t_external();
    logic [31:0] v;
    logic [7:0]  rx;
    logic        ack;
    time         t0;
    int          expc;
    write_cmd(8'h30);
    t0 = $time;
    check("busy external", busy, 8'h01);
    read_res(2, v);
    check("old reading", v[15:0] == 16'hF001, 8'h01);
    repeat (100) @(negedge clk_i);
    write_cmd(8'h30);
    // Both commands reach the core at the same offset before the task returns.
    expc = int'(($time - t0) / (10 * TB_DIV));
    read_res(4, v);
    check("latched reading", v[15:0] == d1, 8'h01);
    check("count nonzero", v[31:16] != 16'h0000, 8'h01);
    check("count range", v[31:16] + 2 >= expc && v[31:16] <= expc + 2, 8'h01);
    check("count high", v[31:24], 8'(expc >> 8));
    @(negedge clk_i);
    d1 = 16'h0777;
    m.start_cond();
    m.xfer(8'h88, 1'b0, rx, ack);
    check("address only ack", ack, 8'h01);
    m.stop_cond();
    read_res(2, v);
    check("re-executed latch", v[15:0] == 16'h0777, 8'h01);
    write_cmd(8'h38);
    write_cmd(8'h38);
    read_res(2, v);
    check("ext difference", v[15:0] == d1 - d2, 8'h01);
  endtask
  task automatic t_test_and_pin();
    logic [31:0] v;
    logic [7:0]  rx;
    logic        ack;
    write_cmd(8'hA5);
    read_res(1, v);
    check("test echo", v[7:0], 8'hA5);
    write_cmd(8'h8C);
    check("busy after down", busy, 8'h00);
    read_res(2, v);
    check("down keeps reading", v[15:0] == d1 - d2, 8'h01);
    m.start_cond();
    m.xfer(8'h8A, 1'b0, rx, ack);
    check("foreign address", ack, 8'h00);
    m.stop_cond();
    @(negedge clk_i);
    pd = 1'b1;
    repeat (10) @(negedge clk_i);
    m.start_cond();
    m.xfer(8'h88, 1'b0, rx, ack);
    check("pin down ack", ack, 8'h00);
    m.stop_cond();
    @(negedge clk_i);
    pd = 1'b0;
    repeat (20) @(negedge clk_i);
    write_cmd(8'h0C);
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #800_000;
    failures++;
    final_report();
  end
  initial begin
    logic [31:0] v;
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    repeat (20) @(negedge clk_i);
    read_res(2, v);
    check("reset reading", v[15:0] == 16'h0000, 8'h01);
    t_internal();
    t_external();
    t_test_and_pin();
    final_report();
  end
endmodule
